// ===== hdl/ufd_uart_data.sv
// uart receive/transmit data path with shadow aliases, fifos and fifo status
`timescale 1ns/1ps
`include "ufd_regs.svh"
// Function
// - sixteen consecutive word aliases all reach receive buffer and transmit holding
// - received bytes come from serial input, or infrared input in infrared mode
// - fifos off: new character overwrites unread buffer and flags overrun
// - fifos on: read gives head; full fifo drops new character, flags overrun
// - fifos off: one write clears holding-empty flag, line status bit 5
// - fifos off: further writes before holding-empty overwrite pending character
// - fifos on: up to fifo depth characters accepted, default sixteen
// - fifos on: writes while transmit fifo full are dropped, contents unchanged
// - status bit 4 is one while fifos on and receive fifo full, reset zero
// - status bit 3 is one while receive fifo not empty, reset zero
// - status bit 2 is one while transmit fifo empty, reset one
// - status bit 1 is one while transmit fifo not full, reset one
module ufd_uart_data #(
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic clk_i, // 250 MHz clock
    input wire logic rst_i, // async reset, active high
    input wire ufd_pkg::ufd_bus_s bus_i, // register bus request
    output logic [31:0] rdata_o, // read data, cycle after read strobe
    input wire logic sin_i, // serial input pin
    input wire logic sir_in_i, // infrared input pin
    output logic sout_o, // serial output pin
    output logic sir_out_n_o, // infrared output, active low
    output logic irq_o // level interrupt
);
    logic [7:0] rx_mem [DEPTH];
    logic [7:0] tx_mem [DEPTH];
    logic [AW:0] rx_cnt_r, rx_cnt_nxt, tx_cnt_r, tx_cnt_nxt;
    logic [AW-1:0] rx_rp_r, rx_rp_nxt, rx_wp_r, rx_wp_nxt, tx_rp_r, tx_rp_nxt, tx_wp_r, tx_wp_nxt;
    logic [3:0] ctrl_r, ctrl_nxt;
    logic oe_r, oe_nxt;
    logic [`UFD_IRQ_W-1:0] ist_r, ist_nxt, imask_r, imask_nxt;
    logic [31:0] rdata_nxt;
    logic irq_nxt;
    logic [2:0] sin_sync_r, sir_sync_r;
    ufd_pkg::ufd_rx_e rx_st_r, rx_st_nxt;
    logic [15:0] rx_div_r, rx_div_nxt;
    logic [3:0] rx_bit_r, rx_bit_nxt;
    logic [7:0] rx_sh_r, rx_sh_nxt;
    ufd_pkg::ufd_tx_e tx_st_r, tx_st_nxt;
    logic [15:0] tx_div_r, tx_div_nxt;
    logic [3:0] tx_bit_r, tx_bit_nxt;
    logic [9:0] tx_sh_r, tx_sh_nxt;
    logic sout_nxt, sirn_nxt;
    logic rx_push, rx_pop, tx_push, tx_pop, rx_in;
    logic hit_shadow, rx_full, tx_full, fifo_en, txe_now, txe_prev_r, oe_clr;

    function automatic logic [AW:0] cap(input logic fifo_on);
        cap = fifo_on ? (AW+1)'(DEPTH) : (AW+1)'(1);
    endfunction

    function automatic logic [AW-1:0] inc(input logic [AW-1:0] p, input logic fifo_on);
        inc = fifo_on ? AW'(p + 1'b1) : p;
    endfunction

    assign fifo_en = ctrl_r[`UFD_CTRL_FIFO_EN];
    assign rx_full = (rx_cnt_r == cap(fifo_en));
    assign tx_full = (tx_cnt_r == cap(fifo_en));
    assign hit_shadow = (bus_i.addr >= `UFD_SHADOW_BASE) && (bus_i.addr <= `UFD_SHADOW_LAST) && (bus_i.addr[1:0] == 2'h0);
    assign rx_pop = bus_i.rd && hit_shadow && (rx_cnt_r != '0);
    assign tx_push = bus_i.wr && hit_shadow;
    assign rx_in = ctrl_r[`UFD_CTRL_IR_MODE] ? ~sir_sync_r[2] : sin_sync_r[2];
    assign txe_now = (tx_cnt_r == '0);

    // pins pass two flops; bit 2 is a third stage for edge-free sampling
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sin_sync_r <= 3'h7;
            sir_sync_r <= 3'h0;
        end else begin
            sin_sync_r <= {sin_sync_r[1:0], sin_i};
            sir_sync_r <= {sir_sync_r[1:0], sir_in_i};
        end
    end

    // receiver: 8N1, samples mid-bit; infrared pulses taken as active-high level
    always_comb begin
        rx_st_nxt = rx_st_r;
        rx_div_nxt = rx_div_r;
        rx_bit_nxt = rx_bit_r;
        rx_sh_nxt = rx_sh_r;
        rx_push = 1'b0;
        case (rx_st_r)
            ufd_pkg::UFD_RX_IDLE: begin
                if (!rx_in) begin
                    rx_st_nxt = ufd_pkg::UFD_RX_START;
                    rx_div_nxt = `UFD_RX_SAMPLE;
                end
            end
            ufd_pkg::UFD_RX_START: begin
                rx_div_nxt = rx_div_r - 16'h0001;
                if (rx_div_r == 16'h0001) begin
                    rx_st_nxt = rx_in ? ufd_pkg::UFD_RX_IDLE : ufd_pkg::UFD_RX_DATA;
                    rx_div_nxt = `UFD_BAUD_DIV;
                    rx_bit_nxt = 4'h0;
                end
            end
            ufd_pkg::UFD_RX_DATA: begin
                rx_div_nxt = rx_div_r - 16'h0001;
                if (rx_div_r == 16'h0001) begin
                    rx_div_nxt = `UFD_BAUD_DIV;
                    rx_sh_nxt = {rx_in, rx_sh_r[7:1]};
                    rx_bit_nxt = rx_bit_r + 4'h1;
                    if (rx_bit_r == 4'h7) begin
                        rx_st_nxt = ufd_pkg::UFD_RX_STOP;
                    end
                end
            end
            ufd_pkg::UFD_RX_STOP: begin
                rx_div_nxt = rx_div_r - 16'h0001;
                if (rx_div_r == 16'h0001) begin
                    rx_st_nxt = ufd_pkg::UFD_RX_IDLE;
                    rx_push = 1'b1;
                end
            end
            default: rx_st_nxt = ufd_pkg::UFD_RX_IDLE;
        endcase
    end

    // transmitter: pulls from fifo, shifts start, 8 data, stop
    always_comb begin
        tx_st_nxt = tx_st_r;
        tx_div_nxt = tx_div_r;
        tx_bit_nxt = tx_bit_r;
        tx_sh_nxt = tx_sh_r;
        tx_pop = 1'b0;
        sout_nxt = sout_o;
        sirn_nxt = 1'b1;
        case (tx_st_r)
            ufd_pkg::UFD_TX_IDLE: begin
                sout_nxt = 1'b1;
                if (!txe_now) begin
                    tx_st_nxt = ufd_pkg::UFD_TX_LOAD;
                end
            end
            ufd_pkg::UFD_TX_LOAD: begin
                tx_sh_nxt = {1'b1, tx_mem[tx_rp_r], 1'b0};
                tx_pop = 1'b1;
                tx_bit_nxt = 4'h0;
                tx_div_nxt = `UFD_BAUD_DIV;
                tx_st_nxt = ufd_pkg::UFD_TX_SHIFT;
            end
            ufd_pkg::UFD_TX_SHIFT: begin
                sout_nxt = tx_sh_r[0];
                sirn_nxt = tx_sh_r[0] | ~ctrl_r[`UFD_CTRL_IR_MODE];
                tx_div_nxt = tx_div_r - 16'h0001;
                if (tx_div_r == 16'h0001) begin
                    tx_div_nxt = `UFD_BAUD_DIV;
                    tx_sh_nxt = {1'b1, tx_sh_r[9:1]};
                    tx_bit_nxt = tx_bit_r + 4'h1;
                    if (tx_bit_r == `UFD_BITS_PER_CHAR) begin
                        tx_st_nxt = ufd_pkg::UFD_TX_IDLE;
                    end
                end
            end
            default: tx_st_nxt = ufd_pkg::UFD_TX_IDLE;
        endcase
    end

    // fifo pointers; with fifos off each fifo is a single slot at index 0
    always_comb begin
        rx_cnt_nxt = rx_cnt_r;
        rx_wp_nxt = rx_wp_r;
        rx_rp_nxt = rx_rp_r;
        tx_cnt_nxt = tx_cnt_r;
        tx_wp_nxt = tx_wp_r;
        tx_rp_nxt = tx_rp_r;
        // overrun is cleared by writing one to line status; a new overrun below wins
        oe_nxt = oe_r & ~oe_clr;
        if (rx_pop) begin
            rx_rp_nxt = inc(rx_rp_r, fifo_en);
            rx_cnt_nxt = rx_cnt_nxt - 1'b1;
        end
        if (rx_push) begin
            if (!rx_full || rx_pop) begin
                rx_wp_nxt = inc(rx_wp_r, fifo_en);
                rx_cnt_nxt = rx_cnt_nxt + 1'b1;
            end else begin
                oe_nxt = 1'b1;
            end
        end
        if (tx_pop) begin
            tx_rp_nxt = inc(tx_rp_r, fifo_en);
            tx_cnt_nxt = tx_cnt_nxt - 1'b1;
        end
        if (tx_push && (!tx_full || tx_pop)) begin
            tx_wp_nxt = inc(tx_wp_r, fifo_en);
            tx_cnt_nxt = tx_cnt_nxt + 1'b1;
        end
        if (ctrl_r[`UFD_CTRL_RX_FLUSH]) begin
            rx_cnt_nxt = '0;
            rx_wp_nxt = '0;
            rx_rp_nxt = '0;
        end
        if (ctrl_r[`UFD_CTRL_TX_FLUSH]) begin
            tx_cnt_nxt = '0;
            tx_wp_nxt = '0;
            tx_rp_nxt = '0;
        end
    end

    // storage has no reset; only the counters define content
    always_ff @(posedge clk_i) begin
        if (rx_push && !fifo_en) begin
            rx_mem[0] <= rx_sh_r;
        end else if (rx_push && (!rx_full || rx_pop)) begin
            rx_mem[rx_wp_r] <= rx_sh_r;
        end
        if (tx_push && !fifo_en && tx_full && !tx_pop) begin
            tx_mem[0] <= bus_i.wdata[7:0];
        end else if (tx_push && (!tx_full || tx_pop)) begin
            tx_mem[tx_wp_r] <= bus_i.wdata[7:0];
        end
    end

    // register file: control, sticky events, read mux
    always_comb begin
        ctrl_nxt = ctrl_r;
        ctrl_nxt[`UFD_CTRL_RX_FLUSH] = 1'b0;
        ctrl_nxt[`UFD_CTRL_TX_FLUSH] = 1'b0;
        imask_nxt = imask_r;
        ist_nxt = ist_r;
        rdata_nxt = 32'h0000_0000;
        oe_clr = 1'b0;
        if (bus_i.wr) begin
            case (bus_i.addr)
                `UFD_CTRL_OFF: begin
                    ctrl_nxt = bus_i.wdata[3:0];
                    if (bus_i.wdata[`UFD_CTRL_FIFO_EN] != fifo_en) begin
                        ctrl_nxt[`UFD_CTRL_RX_FLUSH] = 1'b1;
                        ctrl_nxt[`UFD_CTRL_TX_FLUSH] = 1'b1;
                    end
                end
                `UFD_IRQ_MASK_OFF: imask_nxt = bus_i.wdata[`UFD_IRQ_W-1:0];
                `UFD_IRQ_STAT_OFF: ist_nxt = ist_r & ~bus_i.wdata[`UFD_IRQ_W-1:0];
                default: ;
            endcase
            if (bus_i.addr == `UFD_LINE_OFF && bus_i.wdata[`UFD_LS_OE]) begin
                oe_clr = 1'b1;
            end
        end
        // set wins over a same-cycle clear
        if (rx_push) begin
            ist_nxt[`UFD_IRQ_RX] = 1'b1;
        end
        if (rx_push && rx_full && !rx_pop) begin
            ist_nxt[`UFD_IRQ_OE] = 1'b1;
        end
        if (txe_now && !txe_prev_r) begin
            ist_nxt[`UFD_IRQ_TXE] = 1'b1;
        end
        if (bus_i.rd) begin
            if (hit_shadow) begin
                rdata_nxt = {24'h00_0000, rx_mem[rx_rp_r]};
            end else begin
                case (bus_i.addr)
                    `UFD_STATUS_OFF: begin
                        rdata_nxt[`UFD_ST_RFF] = rx_full && fifo_en;
                        rdata_nxt[`UFD_ST_RFNE] = (rx_cnt_r != '0);
                        rdata_nxt[`UFD_ST_TFE] = txe_now;
                        rdata_nxt[`UFD_ST_TFNF] = !tx_full;
                    end
                    `UFD_CTRL_OFF: rdata_nxt[3:0] = ctrl_r;
                    `UFD_LINE_OFF: begin
                        rdata_nxt[`UFD_LS_DR] = (rx_cnt_r != '0);
                        rdata_nxt[`UFD_LS_OE] = oe_r;
                        rdata_nxt[`UFD_LS_TX_HOLDING_EMPTY] = txe_now;
                        rdata_nxt[`UFD_LS_TEMT] = txe_now && (tx_st_r == ufd_pkg::UFD_TX_IDLE);
                    end
                    `UFD_IRQ_STAT_OFF: rdata_nxt[`UFD_IRQ_W-1:0] = ist_r;
                    `UFD_IRQ_MASK_OFF: rdata_nxt[`UFD_IRQ_W-1:0] = imask_r;
                    default: rdata_nxt = 32'h0000_0000;
                endcase
            end
        end
        irq_nxt = |(ist_nxt & imask_nxt);
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_cnt_r <= '0;
            rx_wp_r <= '0;
            rx_rp_r <= '0;
            tx_cnt_r <= '0;
            tx_wp_r <= '0;
            tx_rp_r <= '0;
            oe_r <= 1'b0;
            ctrl_r <= 4'h0;
            ist_r <= '0;
            imask_r <= '0;
            rdata_o <= 32'h0000_0000;
            irq_o <= 1'b0;
            txe_prev_r <= 1'b1;
            rx_st_r <= ufd_pkg::UFD_RX_IDLE;
            rx_div_r <= 16'h0000;
            rx_bit_r <= 4'h0;
            rx_sh_r <= 8'h00;
            tx_st_r <= ufd_pkg::UFD_TX_IDLE;
            tx_div_r <= 16'h0000;
            tx_bit_r <= 4'h0;
            tx_sh_r <= 10'h3FF;
            sout_o <= 1'b1;
            sir_out_n_o <= 1'b1;
        end else begin
            rx_cnt_r <= rx_cnt_nxt;
            rx_wp_r <= rx_wp_nxt;
            rx_rp_r <= rx_rp_nxt;
            tx_cnt_r <= tx_cnt_nxt;
            tx_wp_r <= tx_wp_nxt;
            tx_rp_r <= tx_rp_nxt;
            oe_r <= oe_nxt;
            ctrl_r <= ctrl_nxt;
            ist_r <= ist_nxt;
            imask_r <= imask_nxt;
            rdata_o <= rdata_nxt;
            irq_o <= irq_nxt;
            txe_prev_r <= txe_now;
            rx_st_r <= rx_st_nxt;
            rx_div_r <= rx_div_nxt;
            rx_bit_r <= rx_bit_nxt;
            rx_sh_r <= rx_sh_nxt;
            tx_st_r <= tx_st_nxt;
            tx_div_r <= tx_div_nxt;
            tx_bit_r <= tx_bit_nxt;
            tx_sh_r <= tx_sh_nxt;
            sout_o <= sout_nxt;
            sir_out_n_o <= sirn_nxt;
        end
    end
endmodule

// ===== hdl/ufd_regs.svh
// register offsets, field positions and timing for the uart data and fifo status block
`ifndef UFD_REGS_SVH
`define UFD_REGS_SVH
`define UFD_ADDR_W 32
`define UFD_SHADOW_BASE 32'h5000_1030
`define UFD_SHADOW_LAST 32'h5000_106C
`define UFD_STATUS_OFF 32'h5000_107C
`define UFD_CTRL_OFF 32'h5000_10F0
`define UFD_LINE_OFF 32'h5000_10F4
`define UFD_IRQ_STAT_OFF 32'h5000_10F8
`define UFD_IRQ_MASK_OFF 32'h5000_10FC
`define UFD_ST_RFF 4
`define UFD_ST_RFNE 3
`define UFD_ST_TFE 2
`define UFD_ST_TFNF 1
`define UFD_CTRL_FIFO_EN 0
`define UFD_CTRL_IR_MODE 1
`define UFD_CTRL_RX_FLUSH 2
`define UFD_CTRL_TX_FLUSH 3
`define UFD_LS_DR 0
`define UFD_LS_OE 1
`define UFD_LS_TX_HOLDING_EMPTY 5
`define UFD_LS_TEMT 6
`define UFD_IRQ_RX 0
`define UFD_IRQ_OE 1
`define UFD_IRQ_TXE 2
`define UFD_IRQ_W 3
`define UFD_BAUD_DIV 16'h0010
`define UFD_BITS_PER_CHAR 4'h9
`define UFD_RX_SAMPLE 16'h0008
`endif

// ===== hdl/ufd_pkg.sv
// types shared by the uart data and fifo status block
package ufd_pkg;
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ufd_bus_s;
    typedef enum logic [1:0] {
        UFD_RX_IDLE = 2'b00,
        UFD_RX_START = 2'b01,
        UFD_RX_DATA = 2'b10,
        UFD_RX_STOP = 2'b11
    } ufd_rx_e;
    typedef enum logic [1:0] {
        UFD_TX_IDLE = 2'b00,
        UFD_TX_SHIFT = 2'b01,
        UFD_TX_LOAD = 2'b10
    } ufd_tx_e;
endpackage

// ===== tb/ufd_uart_data_chk.sv
// assertion checker for the uart data and fifo status block
`timescale 1ns/1ps
`include "ufd_regs.svh"
module ufd_uart_data_chk #(
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic clk_i, // clock
    input wire logic rst_i, // async reset
    input wire ufd_pkg::ufd_bus_s bus_i, // bus request
    input wire logic [31:0] rdata_o, // read data
    input wire logic sin_i, // serial in
    input wire logic sir_in_i, // infrared in
    input wire logic sout_o, // serial out
    input wire logic sir_out_n_o, // infrared out
    input wire logic irq_o // interrupt
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic in_alias, alias_rd, alias_wr, st_rd, ir_r, ir_nxt;
    logic [7:0] quiet_r, quiet_nxt;
    assign in_alias = bus_i.addr >= `UFD_SHADOW_BASE && bus_i.addr <= `UFD_SHADOW_LAST;
    assign alias_rd = bus_i.rd && in_alias;
    assign alias_wr = bus_i.wr && in_alias;
    assign st_rd = bus_i.rd && bus_i.addr == `UFD_STATUS_OFF;
    // quiet counts idle line cycles since the last transmit write; saturates as the idle proof
    always_comb begin
        ir_nxt = (bus_i.wr && bus_i.addr == `UFD_CTRL_OFF) ? bus_i.wdata[`UFD_CTRL_IR_MODE] : ir_r;
        quiet_nxt = (!sout_o || alias_wr) ? 8'h00 : (quiet_r == 8'hFF ? quiet_r : quiet_r + 8'h01);
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ir_r <= 1'b0;
            quiet_r <= 8'h00;
        end else begin
            ir_r <= ir_nxt;
            quiet_r <= quiet_nxt;
        end
    end
    AST_RD_QUIET: assert property (!$past(bus_i.rd) |-> rdata_o == 32'h0)
        else $error("read data not zero outside read answer");
    AST_ALIAS_BYTE: assert property (alias_rd |=> rdata_o[31:8] == 24'h0)
        else $error("alias read upper bits set");
    AST_ST_RSVD: assert property (st_rd |=> rdata_o[31:5] == 27'h0 && !rdata_o[0])
        else $error("status reserved bits set");
    AST_FULL_NE: assert property (st_rd |=> !rdata_o[4] || rdata_o[3])
        else $error("rx full without not empty");
    AST_EMPTY_NF: assert property (st_rd |=> !rdata_o[2] || rdata_o[1])
        else $error("tx empty while full");
    AST_IDLE_EMPTY: assert property (st_rd && quiet_r == 8'hFF && !ir_r |=> rdata_o[2])
        else $error("tx fifo not empty while line idle");
    AST_TX_START: assert property (alias_wr && quiet_r == 8'hFF && !ir_r |-> ##[2:4] !sout_o)
        else $error("transmit write did not start a frame");
    AST_START_LEN: assert property ($fell(sout_o) |-> !sout_o [*8])
        else $error("start bit too short");
    AST_IR_OUT: assert property ($past(ir_r) == ir_r |-> sir_out_n_o == (sout_o || !ir_r))
        else $error("infrared output does not follow the serial output");
endmodule
bind ufd_uart_data ufd_uart_data_chk #(.DEPTH(DEPTH), .AW(AW)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .bus_i(bus_i), .rdata_o(rdata_o), .sin_i(sin_i), .sir_in_i(sir_in_i), .sout_o(sout_o),
    .sir_out_n_o(sir_out_n_o), .irq_o(irq_o));

// ===== tb/ufd_remote_uart.sv
// remote uart model: frames bytes onto the serial or infrared input and captures serial output
`timescale 1ns/1ps
module ufd_remote_uart (
    input wire logic clk_i, // bench clock
    input wire logic sout_i, // serial line from the block
    output logic sin_o, // serial line to the block
    output logic sir_o // infrared line to the block
);
    logic [7:0] rx_q[$];
    logic [7:0] sh;
    initial begin
        sin_o = 1'b1;
        sir_o = 1'b0;
    end
    // 8n1, lsb first, 16 clocks a bit; infrared marks a zero bit with a high pulse
    task automatic send(input logic [7:0] b, input logic ir);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_i);
            sin_o <= ir | f[i];
            sir_o <= ir & !f[i];
            repeat (15) @(posedge clk_i);
        end
    endtask
    // sample mid-bit; a new frame is only looked for after the stop bit middle
    always @(negedge sout_i) begin
        repeat (8) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (16) @(posedge clk_i);
            sh[i] = sout_i;
        end
        repeat (16) @(posedge clk_i);
        rx_q.push_back(sh);
    end
endmodule

// ===== tb/ufd_uart_data_tb_top.sv
// self-checking testbench for the uart data and fifo status block
`timescale 1ns/1ps
`include "ufd_regs.svh"
module ufd_uart_data_tb_top;
    localparam int DEPTH = 4;
    localparam logic [31:0] BASE = `UFD_SHADOW_BASE;
    localparam logic [31:0] ST = `UFD_STATUS_OFF;
    localparam logic [31:0] LINE = `UFD_LINE_OFF;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    ufd_pkg::ufd_bus_s bus_i = '0;
    logic [31:0] rdata_o, d;
    logic sin_i, sir_in_i, sout_o, sir_out_n_o, irq_o;
    int miscompares = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [7:0] exp_q[$];
    logic [7:0] b;
    always #2 clk_i = ~clk_i;
    ufd_uart_data #(.DEPTH(DEPTH), .AW(2)) u_ufd_uart_data (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus_i),
        .rdata_o(rdata_o), .sin_i(sin_i), .sir_in_i(sir_in_i), .sout_o(sout_o), .sir_out_n_o(sir_out_n_o),
        .irq_o(irq_o));
    ufd_remote_uart u_ufd_remote_uart (.clk_i(clk_i), .sout_i(sout_o), .sin_o(sin_i), .sir_o(sir_in_i));
    function automatic logic [31:0] st(input logic rf, input logic ne, input logic te, input logic nf);
        return {27'h0, rf, ne, te, nf, 1'b0};
    endfunction
    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        @(posedge clk_i);
        bus_i <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        bus_i.wr <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        bus_i <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        bus_i.rd <= 1'b0;
        #1 d = rdata_o;
        chk(d, exp);
    endtask
    task automatic tx_cmp();
        chk(u_ufd_remote_uart.rx_q.size(), exp_q.size());
        while (exp_q.size() > 0 && u_ufd_remote_uart.rx_q.size() > 0) begin
            chk(u_ufd_remote_uart.rx_q.pop_front(), exp_q.pop_front());
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // whole run needs about 3400 cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_of_test();
        end
    end
    initial begin
        void'($urandom(32'hED3B));
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (300) @(posedge clk_i);
        rchk(ST, st(0, 0, 1, 1));
        rchk(32'h5000_1070, 32'h0);
        b = 8'($urandom);
        exp_q.push_back(b);
        wr(BASE, {24'h0, b});
        repeat (4) @(posedge clk_i);
        wr(BASE + 32'h3C, $urandom);
        rchk(LINE, 32'h0);
        b = 8'($urandom);
        exp_q.push_back(b);
        wr(BASE + 32'h4, {24'h0, b});
        repeat (500) @(posedge clk_i);
        tx_cmp();
        rchk(LINE, 32'h60);
        wr(`UFD_CTRL_OFF, 32'h1);
        b = 8'($urandom);
        exp_q.push_back(b);
        wr(BASE, {24'h0, b});
        repeat (4) @(posedge clk_i);
        // one more write than fits: the last one must be dropped
        for (int i = 0; i <= DEPTH; i++) begin
            b = 8'($urandom);
            if (i < DEPTH) exp_q.push_back(b);
            wr(BASE + 32'(4 * i), {24'h0, b});
        end
        rchk(ST, st(0, 0, 0, 0));
        repeat (1100) @(posedge clk_i);
        tx_cmp();
        rchk(ST, st(0, 0, 1, 1));
        for (int i = 0; i <= DEPTH; i++) begin
            b = 8'($urandom);
            if (i < DEPTH) exp_q.push_back(b);
            u_ufd_remote_uart.send(b, 1'b0);
        end
        repeat (20) @(posedge clk_i);
        rchk(ST, st(1, 1, 1, 1));
        rchk(LINE, 32'h63);
        chk({31'h0, irq_o}, 32'h0);
        wr(`UFD_IRQ_MASK_OFF, 32'h2);
        repeat (3) @(posedge clk_i);
        #1 chk({31'h0, irq_o}, 32'h1);
        wr(`UFD_IRQ_STAT_OFF, 32'h2);
        wr(LINE, 32'h2);
        repeat (3) @(posedge clk_i);
        #1 chk({31'h0, irq_o}, 32'h0);
        rchk(LINE, 32'h61);
        wr(`UFD_IRQ_MASK_OFF, 32'h0);
        for (int i = 0; i < DEPTH; i++) begin
            rchk(BASE + 32'(4 * (15 - i)), {24'h0, exp_q.pop_front()});
        end
        rchk(ST, st(0, 0, 1, 1));
        // fifos off, infrared input: the second byte overwrites the unread first
        wr(`UFD_CTRL_OFF, 32'h2);
        u_ufd_remote_uart.send(8'($urandom), 1'b1);
        b = 8'($urandom);
        u_ufd_remote_uart.send(b, 1'b1);
        repeat (20) @(posedge clk_i);
        rchk(ST, st(0, 1, 1, 1));
        // software looks at data ready before it takes the byte
        rchk(LINE, 32'h63);
        rchk(BASE + 32'h8, {24'h0, b});
        rchk(LINE, 32'h62);
        // a frame sent in infrared mode, so the infrared output assertion sees real traffic
        b = 8'($urandom);
        exp_q.push_back(b);
        wr(BASE + 32'h3C, {24'h0, b});
        repeat (200) @(posedge clk_i);
        tx_cmp();
        end_of_test();
    end
endmodule
